// *** design/phsp_dev.sv ***
// Device end: initiator and configuration target with parity checking
`timescale 1ns/1ps
`default_nettype none
module phsp_dev
  import phsp_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // Mode strap
  input wire logic I_DEMULTIPLEXED_BUS_MODE,
  // Initiator request side
  input wire logic I_MST_REQ,
  input wire logic I_MST_WRITE,
  input wire logic [31:0] I_MST_ADDR,
  input wire logic [31:0] I_MST_WDATA,
  input wire logic I_MST_READY,
  output logic O_MST_BUSY,
  output logic O_MST_DONE,
  output logic O_MST_STOPPED,
  output logic O_MST_ABORT_IRQ,
  output logic [31:0] O_MST_RDATA,
  // Configuration target side
  input wire logic [31:0] I_CFG_RDATA,
  input wire logic I_CFG_READY,
  input wire logic I_TGT_RETRY,
  output logic O_CFG_WE,
  output logic [31:0] O_CFG_WDATA,
  output logic O_CFG_ACCESS,
  // Parity status
  output logic O_PERR_EVENT,
  output logic O_PERR_SEEN,
  input wire logic I_PERR_CLEAR,
  // Bus
  phsp_if.dev BUS
);
  typedef enum logic [2:0] {
    PHSP_IDLE = 3'b000, PHSP_M_ADDR = 3'b001, PHSP_M_DATA = 3'b011,
    PHSP_T_DEC = 3'b100, PHSP_T_DATA = 3'b101, PHSP_T_END = 3'b111
  } phsp_state_t;
  typedef struct packed {
    phsp_state_t st;
    logic [2:0] tmo;
    logic wr;
    logic [31:0] dout;
    logic dout_oe;
    logic [3:0] cout;
    logic cout_oe;
    logic par_o, par_oe;
    logic irdy, trdy, stop, devsel, frame;
    logic par_chk;
    logic [35:0] prev_bits;
    logic perr_o;
    logic perr_ev, perr_seen;
    logic done, stopped, abort;
    logic [31:0] rdata, cwdata;
    logic cwe;
  } phsp_dev_state_t;
  phsp_dev_state_t s_r, s_nxt;
  logic cfg_hit;
  logic xfer;
  logic par_bad;
  // Configuration decode: command in PCI mode, plain chip select in demultiplexed_bus_mode
  // config command decode
  assign cfg_hit = !BUS.frame_n && BUS.idsel &&
    (I_DEMULTIPLEXED_BUS_MODE ||
     BUS.cbe == PHSP_CMD_CFG_RD || BUS.cbe == PHSP_CMD_CFG_WR);
  assign xfer = !BUS.irdy_n && !BUS.trdy_n;
  // even parity check, PAR one cycle behind its ad cycle
  assign par_bad = s_r.par_chk && !I_DEMULTIPLEXED_BUS_MODE &&
    (phsp_parity(s_r.prev_bits[35:4], s_r.prev_bits[3:0]) != BUS.par);
  // Next state of the whole end
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.stopped = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.cwe = 1'b0;
    s_nxt.perr_ev = 1'b0;
    s_nxt.par_o = I_DEMULTIPLEXED_BUS_MODE ? PHSP_PAR_DEMULTIPLEXED_BUS_MODE_VAL :
      phsp_parity(s_r.dout, s_r.cout);
    s_nxt.par_oe = s_r.dout_oe;
    s_nxt.prev_bits = {BUS.ad, BUS.cbe};
    s_nxt.par_chk = 1'b0;
    s_nxt.perr_o = par_bad;
    s_nxt.perr_seen = par_bad || (s_r.perr_seen && !I_PERR_CLEAR);
    s_nxt.perr_ev = par_bad;
    case (s_r.st)
      PHSP_IDLE: begin
        s_nxt.irdy = 1'b0;
        s_nxt.trdy = 1'b0;
        s_nxt.stop = 1'b0;
        s_nxt.devsel = 1'b0;
        s_nxt.dout_oe = 1'b0;
        s_nxt.cout_oe = 1'b0;
        if (I_MST_REQ && BUS.frame_n) begin
          s_nxt.st = PHSP_M_ADDR;
          s_nxt.frame = 1'b1;
          s_nxt.wr = I_MST_WRITE;
          s_nxt.dout = I_MST_ADDR;
          s_nxt.dout_oe = 1'b1;
          s_nxt.cout = I_MST_WRITE ? PHSP_CMD_MEM_WR : PHSP_CMD_MEM_RD;
          s_nxt.cout_oe = 1'b1;
          s_nxt.tmo = 3'h0;
        end else if (cfg_hit) begin
          s_nxt.par_chk = 1'b1;
          s_nxt.wr = I_DEMULTIPLEXED_BUS_MODE ? BUS.cbe[0] : (BUS.cbe == PHSP_CMD_CFG_WR);
          s_nxt.st = PHSP_T_DEC;
          s_nxt.devsel = 1'b1;
        end
      end
      PHSP_M_ADDR: begin
        // single phase, frame drops with irdy on writes; read irdy waits for I_MST_READY
        s_nxt.frame = 1'b0;
        s_nxt.irdy = I_MST_WRITE ? 1'b1 : I_MST_READY;
        s_nxt.dout = I_MST_WDATA;
        s_nxt.dout_oe = s_r.wr;
        s_nxt.cout = 4'h0;
        s_nxt.st = PHSP_M_DATA;
        s_nxt.tmo = 3'h1;
      end
      PHSP_M_DATA: begin
        s_nxt.par_chk = !s_r.wr && xfer;
        if (!s_r.wr) begin
          s_nxt.irdy = I_MST_READY;
        end
        if (BUS.devsel_n && s_r.tmo < 3'(PHSP_DEVSEL_TIMEOUT_CYC)) begin
          s_nxt.tmo = s_r.tmo + 3'h1;
        end
        if (xfer) begin
          s_nxt.rdata = BUS.ad;
          s_nxt.done = 1'b1;
          s_nxt.st = PHSP_IDLE;
          s_nxt.irdy = 1'b0;
          s_nxt.dout_oe = 1'b0;
          s_nxt.cout_oe = 1'b0;
        end else if (!BUS.stop_n) begin
          s_nxt.stopped = 1'b1;
          s_nxt.st = PHSP_IDLE;
          s_nxt.irdy = 1'b0;
          s_nxt.dout_oe = 1'b0;
          s_nxt.cout_oe = 1'b0;
        end else if (BUS.devsel_n && s_r.tmo >= 3'(PHSP_DEVSEL_TIMEOUT_CYC)) begin
          s_nxt.abort = 1'b1;
          s_nxt.st = PHSP_IDLE;
          s_nxt.irdy = 1'b0;
          s_nxt.dout_oe = 1'b0;
          s_nxt.cout_oe = 1'b0;
        end
      end
      PHSP_T_DEC: begin
        s_nxt.st = PHSP_T_DATA;
        s_nxt.stop = I_TGT_RETRY;
        s_nxt.trdy = !I_TGT_RETRY && I_CFG_READY;
        s_nxt.dout = I_CFG_RDATA;
        s_nxt.dout_oe = !s_r.wr;
      end
      PHSP_T_DATA: begin
        s_nxt.par_chk = s_r.wr && xfer;
        s_nxt.trdy = !s_r.stop && I_CFG_READY;
        s_nxt.dout = I_CFG_RDATA;
        if (xfer || (s_r.stop && BUS.frame_n)) begin
          s_nxt.cwe = s_r.wr && xfer;
          s_nxt.cwdata = BUS.ad;
          s_nxt.st = PHSP_T_END;
          s_nxt.trdy = 1'b0;
          s_nxt.stop = 1'b0;
          s_nxt.devsel = 1'b0;
          s_nxt.dout_oe = 1'b0;
        end
      end
      PHSP_T_END: begin
        s_nxt.st = PHSP_IDLE;
      end
      default: begin
        s_nxt.st = PHSP_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign BUS.dev_frame_o = !s_r.frame;
  assign BUS.dev_frame_oe = s_r.st == PHSP_M_ADDR || s_r.frame;
  assign BUS.dev_irdy_o = !s_r.irdy;
  assign BUS.dev_irdy_oe = s_r.st == PHSP_M_DATA;
  assign BUS.dev_trdy_o = !s_r.trdy;
  assign BUS.dev_trdy_oe = s_r.st == PHSP_T_DATA || s_r.st == PHSP_T_DEC;
  assign BUS.dev_stop_o = !s_r.stop;
  assign BUS.dev_stop_oe = BUS.dev_trdy_oe;
  assign BUS.dev_devsel_o = !s_r.devsel;
  assign BUS.dev_devsel_oe = BUS.dev_trdy_oe;
  assign BUS.dev_perr_o = !s_r.perr_o;
  assign BUS.dev_perr_oe = s_r.perr_o;
  assign BUS.dev_ad_o = s_r.dout;
  assign BUS.dev_ad_oe = s_r.dout_oe;
  assign BUS.dev_cbe_o = s_r.cout;
  assign BUS.dev_cbe_oe = s_r.cout_oe;
  assign BUS.dev_par_o = s_r.par_o;
  assign BUS.dev_par_oe = s_r.par_oe;
  // User-side outputs
  assign O_MST_BUSY = s_r.st == PHSP_M_ADDR || s_r.st == PHSP_M_DATA;
  assign O_MST_DONE = s_r.done;
  assign O_MST_STOPPED = s_r.stopped;
  assign O_MST_ABORT_IRQ = s_r.abort;
  assign O_MST_RDATA = s_r.rdata;
  assign O_CFG_WE = s_r.cwe;
  assign O_CFG_WDATA = s_r.cwdata;
  assign O_CFG_ACCESS = s_r.devsel;
  assign O_PERR_EVENT = s_r.perr_ev;
  assign O_PERR_SEEN = s_r.perr_seen;
endmodule : phsp_dev
`default_nettype wire

// *** design/phsp_hst.sv ***
// Partner end: initiator of configuration cycles and simple target
`timescale 1ns/1ps
`default_nettype none
module phsp_hst
  import phsp_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // Mode strap
  input wire logic I_DEMULTIPLEXED_BUS_MODE,
  // Configuration request side
  input wire logic I_CFG_REQ,
  input wire logic I_CFG_WRITE,
  input wire logic [31:0] I_CFG_WDATA,
  output logic O_CFG_BUSY,
  output logic O_CFG_DONE,
  output logic O_CFG_STOPPED,
  output logic O_CFG_ABORT,
  output logic [31:0] O_CFG_RDATA,
  // Memory target side
  input wire logic [31:0] I_TGT_RDATA,
  input wire logic I_TGT_READY,
  output logic O_TGT_WE,
  output logic [31:0] O_TGT_WDATA,
  // Bus
  phsp_if.hst BUS
);
  typedef enum logic [2:0] {
    PHSP_H_IDLE = 3'b000, PHSP_H_ADDR = 3'b001, PHSP_H_DATA = 3'b011,
    PHSP_H_TDEC = 3'b100, PHSP_H_TDATA = 3'b101
  } phsp_hst_st_t;
  typedef struct packed {
    phsp_hst_st_t st;
    logic [2:0] tmo;
    logic wr;
    logic [31:0] dout;
    logic dout_oe;
    logic [3:0] cout;
    logic cout_oe, par_o, par_oe, idsel, frame, irdy, trdy, devsel;
    logic done, stopped, abort, twe;
    logic [31:0] rdata, twdata;
  } phsp_hst_state_t;
  phsp_hst_state_t s_r, s_nxt;
  logic xfer;
  assign xfer = !BUS.irdy_n && !BUS.trdy_n;
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.stopped = 1'b0;
    s_nxt.abort = 1'b0;
    s_nxt.twe = 1'b0;
    s_nxt.par_o = I_DEMULTIPLEXED_BUS_MODE ? PHSP_PAR_DEMULTIPLEXED_BUS_MODE_VAL :
      phsp_parity(s_r.dout, s_r.cout);
    s_nxt.par_oe = s_r.dout_oe;
    case (s_r.st)
      PHSP_H_IDLE: begin
        s_nxt.dout_oe = 1'b0;
        s_nxt.cout_oe = 1'b0;
        if (I_CFG_REQ && BUS.frame_n) begin
          s_nxt.idsel = 1'b1;
          s_nxt.frame = 1'b1;
          s_nxt.wr = I_CFG_WRITE;
          s_nxt.dout = 32'h0000_0000;
          s_nxt.dout_oe = 1'b1;
          s_nxt.cout = I_CFG_WRITE ? PHSP_CMD_CFG_WR : PHSP_CMD_CFG_RD;
          s_nxt.cout_oe = 1'b1;
          s_nxt.st = PHSP_H_ADDR;
        end else if (!BUS.frame_n && (BUS.cbe == PHSP_CMD_MEM_RD ||
                                       BUS.cbe == PHSP_CMD_MEM_WR)) begin
          s_nxt.wr = BUS.cbe == PHSP_CMD_MEM_WR;
          s_nxt.devsel = 1'b1;
          s_nxt.st = PHSP_H_TDEC;
        end
      end
      PHSP_H_ADDR: begin
        s_nxt.frame = 1'b0;
        s_nxt.idsel = 1'b0;
        s_nxt.irdy = 1'b1;
        s_nxt.dout = I_CFG_WDATA;
        s_nxt.dout_oe = s_r.wr;
        s_nxt.cout = 4'h0;
        s_nxt.tmo = 3'h1;
        s_nxt.st = PHSP_H_DATA;
      end
      PHSP_H_DATA: begin
        if (BUS.devsel_n && s_r.tmo < 3'(PHSP_DEVSEL_TIMEOUT_CYC)) begin
          s_nxt.tmo = s_r.tmo + 3'h1;
        end
        if (xfer || !BUS.stop_n ||
            (BUS.devsel_n && s_r.tmo >= 3'(PHSP_DEVSEL_TIMEOUT_CYC))) begin
          s_nxt.rdata = BUS.ad;
          s_nxt.done = xfer;
          s_nxt.stopped = !xfer && !BUS.stop_n;
          s_nxt.abort = !xfer && BUS.stop_n;
          s_nxt.irdy = 1'b0;
          s_nxt.dout_oe = 1'b0;
          s_nxt.cout_oe = 1'b0;
          s_nxt.st = PHSP_H_IDLE;
        end
      end
      PHSP_H_TDEC: begin
        s_nxt.trdy = I_TGT_READY;
        s_nxt.dout = I_TGT_RDATA;
        s_nxt.dout_oe = !s_r.wr;
        s_nxt.st = PHSP_H_TDATA;
      end
      PHSP_H_TDATA: begin
        s_nxt.trdy = I_TGT_READY;
        s_nxt.dout = I_TGT_RDATA;
        if (xfer) begin
          s_nxt.twe = s_r.wr;
          s_nxt.twdata = BUS.ad;
          s_nxt.trdy = 1'b0;
          s_nxt.devsel = 1'b0;
          s_nxt.dout_oe = 1'b0;
          s_nxt.st = PHSP_H_IDLE;
        end
      end
      default: begin
        s_nxt.st = PHSP_H_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign BUS.hst_frame_o = !s_r.frame;
  assign BUS.hst_frame_oe = s_r.st == PHSP_H_ADDR || s_r.frame;
  assign BUS.hst_irdy_o = !s_r.irdy;
  assign BUS.hst_irdy_oe = s_r.st == PHSP_H_DATA;
  assign BUS.hst_trdy_o = !s_r.trdy;
  assign BUS.hst_trdy_oe = s_r.st == PHSP_H_TDEC || s_r.st == PHSP_H_TDATA;
  assign BUS.hst_devsel_o = !s_r.devsel;
  assign BUS.hst_devsel_oe = BUS.hst_trdy_oe;
  assign BUS.hst_stop_o = 1'b1;
  assign BUS.hst_stop_oe = BUS.hst_trdy_oe;
  assign BUS.hst_perr_o = 1'b1;
  assign BUS.hst_perr_oe = 1'b0;
  assign BUS.hst_ad_o = s_r.dout;
  assign BUS.hst_ad_oe = s_r.dout_oe;
  assign BUS.hst_cbe_o = s_r.cout;
  assign BUS.hst_cbe_oe = s_r.cout_oe;
  assign BUS.hst_par_o = s_r.par_o;
  assign BUS.hst_par_oe = s_r.par_oe;
  assign BUS.hst_idsel_o = s_r.idsel;
  // User-side outputs
  assign O_CFG_BUSY = s_r.st == PHSP_H_ADDR || s_r.st == PHSP_H_DATA;
  assign O_CFG_DONE = s_r.done;
  assign O_CFG_STOPPED = s_r.stopped;
  assign O_CFG_ABORT = s_r.abort;
  assign O_CFG_RDATA = s_r.rdata;
  assign O_TGT_WE = s_r.twe;
  assign O_TGT_WDATA = s_r.twdata;
endmodule : phsp_hst
`default_nettype wire

// *** design/phsp_if.sv ***
// Interface carrying the shared PCI handshake, select and parity wires
`timescale 1ns/1ps
`default_nettype none
interface phsp_if;
  // Wire levels; handshake wires active low as on the bus (1 = released), idsel active high, data lines released low
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic stop_n;
  logic devsel_n;
  logic perr_n;
  logic idsel;
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par;
  // Drive and enable from the device end
  logic dev_irdy_o, dev_irdy_oe, dev_trdy_o, dev_trdy_oe, dev_stop_o, dev_stop_oe;
  logic dev_devsel_o, dev_devsel_oe, dev_perr_o, dev_perr_oe, dev_frame_o, dev_frame_oe;
  logic [31:0] dev_ad_o;
  logic dev_ad_oe;
  logic [3:0] dev_cbe_o;
  logic dev_cbe_oe;
  logic dev_par_o, dev_par_oe;
  // Drive and enable from the partner end
  logic hst_irdy_o, hst_irdy_oe, hst_trdy_o, hst_trdy_oe, hst_stop_o, hst_stop_oe;
  logic hst_devsel_o, hst_devsel_oe, hst_perr_o, hst_perr_oe, hst_frame_o, hst_frame_oe;
  logic [31:0] hst_ad_o;
  logic hst_ad_oe;
  logic [3:0] hst_cbe_o;
  logic hst_cbe_oe;
  logic hst_par_o, hst_par_oe;
  logic hst_idsel_o;
  // Pull-ups on controls, keepers low on data
  assign frame_n = dev_frame_oe ? dev_frame_o : (hst_frame_oe ? hst_frame_o : 1'b1);
  assign irdy_n = dev_irdy_oe ? dev_irdy_o : (hst_irdy_oe ? hst_irdy_o : 1'b1);
  assign trdy_n = dev_trdy_oe ? dev_trdy_o : (hst_trdy_oe ? hst_trdy_o : 1'b1);
  assign stop_n = dev_stop_oe ? dev_stop_o : (hst_stop_oe ? hst_stop_o : 1'b1);
  assign devsel_n = dev_devsel_oe ? dev_devsel_o : (hst_devsel_oe ? hst_devsel_o : 1'b1);
  assign perr_n = dev_perr_oe ? dev_perr_o : (hst_perr_oe ? hst_perr_o : 1'b1);
  assign ad = dev_ad_oe ? dev_ad_o : (hst_ad_oe ? hst_ad_o : 32'h0000_0000);
  assign cbe = dev_cbe_oe ? dev_cbe_o : (hst_cbe_oe ? hst_cbe_o : 4'h0);
  assign par = dev_par_oe ? dev_par_o : (hst_par_oe ? hst_par_o : 1'b0);
  assign idsel = hst_idsel_o;
  modport dev (
    input frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n, idsel, ad, cbe, par,
    output dev_irdy_o, dev_irdy_oe, dev_trdy_o, dev_trdy_oe, dev_stop_o, dev_stop_oe,
    output dev_devsel_o, dev_devsel_oe, dev_perr_o, dev_perr_oe, dev_frame_o, dev_frame_oe,
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe
  );
  modport hst (
    input frame_n, irdy_n, trdy_n, stop_n, devsel_n, perr_n, ad, cbe, par,
    output hst_irdy_o, hst_irdy_oe, hst_trdy_o, hst_trdy_oe, hst_stop_o, hst_stop_oe,
    output hst_devsel_o, hst_devsel_oe, hst_perr_o, hst_perr_oe, hst_frame_o, hst_frame_oe,
    output hst_ad_o, hst_ad_oe, hst_cbe_o, hst_cbe_oe, hst_par_o, hst_par_oe, hst_idsel_o
  );
endinterface : phsp_if
`default_nettype wire

// *** design/phsp_pkg.sv ***
// Package with encodings, timing counts and behaviour notes for the PCI handshake ends
// Notes on behaviour
// - Data phase completes when IRDY and TRDY asserted
// - Target TRDY only with data ready
// - Roles decide who drives which handshake
// - Target STOP forces initiator to terminate
// - IDSEL plus config command gives DEVSEL next
// - Demultiplexed_bus_mode mode uses IDSEL as chip select
// - Target asserts DEVSEL on own decode
// - No DEVSEL in six cycles aborts, interrupts
// - Other initiators abort after six cycles
// - DEVSEL still generated in demultiplexed_bus_mode mode
// - PERR two clocks after bad cycle
// - PAR even parity, one clock late
// - Mode input high selects demultiplexed_bus_mode, PAR zero
// - FRAME deassertion marks final data phase
package phsp_pkg;
  localparam logic [3:0] PHSP_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PHSP_CMD_CFG_WR = 4'hB;
  localparam logic [3:0] PHSP_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PHSP_CMD_MEM_WR = 4'h7;
  localparam int PHSP_DEVSEL_TIMEOUT_CYC = 6;
  localparam int PHSP_PERR_DELAY_CYC = 2;
  localparam logic PHSP_PAR_DEMULTIPLEXED_BUS_MODE_VAL = 1'b0;
  // Even parity over data and command lines
  function automatic logic phsp_parity(input logic [31:0] ad, input logic [3:0] cbe);
    phsp_parity = ^{ad, cbe};
  endfunction : phsp_parity
endpackage : phsp_pkg

// *** tb/pci_handshake_select_parity_test.sv ***
// Testbench: both ends on one bus, a second device facing a scripted far end
`timescale 1ns/1ps
`default_nettype none
module pci_handshake_select_parity_test
  import phsp_pkg::*;
;
  logic clk, rst_n, mode, mst_req, mst_write, mst_ready, cfg_ready, tgt_retry, perr_clr;
  logic cfg_req, cfg_write, tgt_ready, mst_done, dev_we, h_done, h_stop, h_abort, t_we;
  logic abort2, perr2, seen2, seen1;
  logic [31:0] mst_addr, mst_wdata, cfg_rdata, cfg_wdata, tgt_rdata;
  logic [31:0] mst_rdata, dev_wdata, h_rdata, t_wdata, we_d, twe_d;
  int miscompares, num_checks, cyc, n_we, n_twe, n_ab, fr_cyc, ab_cyc, par_hi, i;
  phsp_if u_phsp_if ();
  phsp_if u_phsp_if_2 ();
  // Device end, host end and a second device with the same user inputs
  phsp_dev u_phsp_dev (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_DEMULTIPLEXED_BUS_MODE(mode),
    .I_MST_REQ(mst_req), .I_MST_WRITE(mst_write), .I_MST_ADDR(mst_addr),
    .I_MST_WDATA(mst_wdata), .I_MST_READY(mst_ready), .O_MST_BUSY(), .O_MST_DONE(mst_done),
    .O_MST_STOPPED(), .O_MST_ABORT_IRQ(), .O_MST_RDATA(mst_rdata), .I_CFG_RDATA(cfg_rdata),
    .I_CFG_READY(cfg_ready), .I_TGT_RETRY(tgt_retry), .O_CFG_WE(dev_we),
    .O_CFG_WDATA(dev_wdata), .O_CFG_ACCESS(), .O_PERR_EVENT(), .O_PERR_SEEN(seen1),
    .I_PERR_CLEAR(perr_clr), .BUS(u_phsp_if));
  phsp_dev u_phsp_dev_2 (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_DEMULTIPLEXED_BUS_MODE(mode),
    .I_MST_REQ(mst_req), .I_MST_WRITE(mst_write), .I_MST_ADDR(mst_addr),
    .I_MST_WDATA(mst_wdata), .I_MST_READY(mst_ready), .O_MST_BUSY(), .O_MST_DONE(),
    .O_MST_STOPPED(), .O_MST_ABORT_IRQ(abort2), .O_MST_RDATA(), .I_CFG_RDATA(cfg_rdata),
    .I_CFG_READY(cfg_ready), .I_TGT_RETRY(tgt_retry), .O_CFG_WE(), .O_CFG_WDATA(),
    .O_CFG_ACCESS(), .O_PERR_EVENT(perr2), .O_PERR_SEEN(seen2),
    .I_PERR_CLEAR(perr_clr), .BUS(u_phsp_if_2));
  phsp_hst u_phsp_hst (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_DEMULTIPLEXED_BUS_MODE(mode),
    .I_CFG_REQ(cfg_req), .I_CFG_WRITE(cfg_write), .I_CFG_WDATA(cfg_wdata), .O_CFG_BUSY(),
    .O_CFG_DONE(h_done), .O_CFG_STOPPED(h_stop), .O_CFG_ABORT(h_abort),
    .O_CFG_RDATA(h_rdata), .I_TGT_RDATA(tgt_rdata), .I_TGT_READY(tgt_ready),
    .O_TGT_WE(t_we), .O_TGT_WDATA(t_wdata), .BUS(u_phsp_if));
  phsp_checker u_phsp_checker (.I_CLK_SYS(clk), .I_RESET_N(rst_n),
    .I_DEMULTIPLEXED_BUS_MODE(mode), .frame_n(u_phsp_if.frame_n), .irdy_n(u_phsp_if.irdy_n),
    .trdy_n(u_phsp_if.trdy_n), .stop_n(u_phsp_if.stop_n), .devsel_n(u_phsp_if.devsel_n),
    .perr_n(u_phsp_if.perr_n), .idsel(u_phsp_if.idsel), .ad(u_phsp_if.ad), .cbe(u_phsp_if.cbe),
    .par(u_phsp_if.par), .dev_frame_oe(u_phsp_if.dev_frame_oe),
    .dev_ad_oe(u_phsp_if.dev_ad_oe), .dev_par_oe(u_phsp_if.dev_par_oe));
  // Clock at 250 MHz
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Pulse capture, abort timing and timeout
  always @(posedge clk) begin
    cyc++;
    if (dev_we) begin
      n_we++;
      we_d = dev_wdata;
    end
    if (t_we) begin
      n_twe++;
      twe_d = t_wdata;
    end
    if ($fell(u_phsp_if_2.frame_n)) fr_cyc = cyc;
    if (abort2) begin
      n_ab++;
      ab_cyc = cyc;
    end
    if (mode && u_phsp_if.par) par_hi++;
    if (cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Final report and end of run
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Host end issues one config cycle and waits for its outcome
  task host_cfg(input logic wr, input logic [31:0] wd);
    int k;
    @(posedge clk);
    cfg_req <= 1'h1;
    cfg_write <= wr;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_req <= 1'h0;
    for (k = 0; k < 30 && !(h_done || h_stop || h_abort); k++) @(negedge clk);
  endtask : host_cfg
  // Device end issues one memory cycle against a stalling far side
  task dev_mst(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    {mst_ready, tgt_ready} <= 2'h0;
    mst_req <= 1'h1;
    mst_write <= wr;
    mst_addr <= a;
    mst_wdata <= wd;
    @(posedge clk);
    mst_req <= 1'h0;
    repeat (3) @(posedge clk);
    {mst_ready, tgt_ready} <= 2'h3;
    for (k = 0; k < 30 && !mst_done; k++) @(negedge clk);
  endtask : dev_mst
  // Main sequence
  initial begin
    {rst_n, mode, mst_req, mst_write, mst_ready, cfg_ready, tgt_retry} = '0;
    {perr_clr, cfg_req, cfg_write, tgt_ready} = '0;
    {mst_addr, mst_wdata, cfg_rdata, cfg_wdata, tgt_rdata} = '0;
    {u_phsp_if_2.hst_frame_oe, u_phsp_if_2.hst_irdy_oe, u_phsp_if_2.hst_trdy_oe} = '0;
    {u_phsp_if_2.hst_stop_oe, u_phsp_if_2.hst_devsel_oe, u_phsp_if_2.hst_perr_oe} = '0;
    {u_phsp_if_2.hst_ad_oe, u_phsp_if_2.hst_cbe_oe, u_phsp_if_2.hst_par_oe} = '0;
    u_phsp_if_2.hst_idsel_o = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    cfg_ready <= 1'h1;
    cfg_rdata <= 32'h1234_5678;
    host_cfg(1'h1, 32'hA5A5_0F0F);
    chk("cfg_wr_done", 32'h1, h_done);
    repeat (3) @(negedge clk);
    chk("cfg_we_count", 32'h1, n_we);
    chk("cfg_wdata", 32'hA5A5_0F0F, we_d);
    host_cfg(1'h0, 32'h0);
    chk("cfg_rdata", 32'h1234_5678, h_rdata);
    @(posedge clk);
    tgt_retry <= 1'h1;
    host_cfg(1'h1, 32'h0000_0BAD);
    chk("retry_stopped", 32'h1, h_stop);
    repeat (3) @(negedge clk);
    chk("retry_no_write", 32'h1, n_we);
    @(posedge clk);
    tgt_retry <= 1'h0;
    dev_mst(1'h1, 32'h0000_1000, 32'hDEAD_BEEF);
    chk("mst_wr_done", 32'h1, mst_done);
    repeat (10) @(negedge clk);
    chk("tgt_wdata", 32'hDEAD_BEEF, twe_d);
    chk("abort_count", 32'h1, n_ab);
    // Registered pulse lands one or two edges after the sixth idle cycle
    chk("abort_delay", 32'h1, ab_cyc - fr_cyc >= PHSP_DEVSEL_TIMEOUT_CYC && ab_cyc - fr_cyc <= 8);
    @(posedge clk);
    tgt_rdata <= 32'hCAFE_0001;
    dev_mst(1'h0, 32'h0000_2000, 32'h0);
    chk("mst_rdata", 32'hCAFE_0001, mst_rdata);
    repeat (10) @(negedge clk);
    chk("abort_count_rd", 32'h2, n_ab);
    // Scripted far end writes config with bad data parity
    @(posedge clk);
    {u_phsp_if_2.hst_frame_oe, u_phsp_if_2.hst_ad_oe, u_phsp_if_2.hst_cbe_oe} <= 3'h7;
    {u_phsp_if_2.hst_frame_o, u_phsp_if_2.hst_idsel_o} <= 2'h1;
    u_phsp_if_2.hst_ad_o <= 32'h0;
    u_phsp_if_2.hst_cbe_o <= PHSP_CMD_CFG_WR;
    @(posedge clk);
    {u_phsp_if_2.hst_frame_o, u_phsp_if_2.hst_idsel_o, u_phsp_if_2.hst_irdy_o} <= 3'h4;
    {u_phsp_if_2.hst_irdy_oe, u_phsp_if_2.hst_par_oe} <= 2'h3;
    u_phsp_if_2.hst_ad_o <= 32'h0000_00F1;
    u_phsp_if_2.hst_cbe_o <= 4'h0;
    u_phsp_if_2.hst_par_o <= ^{32'h0, PHSP_CMD_CFG_WR};
    @(posedge clk);
    u_phsp_if_2.hst_par_o <= ~^{32'h0000_00F1, 4'h0};
    @(negedge clk);
    for (i = 0; i < 20 && u_phsp_if_2.trdy_n !== 1'h0; i++) @(negedge clk);
    chk("bad_par_trdy", 32'h0, u_phsp_if_2.trdy_n);
    @(posedge clk);
    {u_phsp_if_2.hst_frame_oe, u_phsp_if_2.hst_irdy_oe} <= 2'h0;
    {u_phsp_if_2.hst_ad_oe, u_phsp_if_2.hst_cbe_oe} <= 2'h0;
    @(negedge clk);
    chk("perr_not_early", 32'h1, u_phsp_if_2.perr_n);
    @(posedge clk);
    u_phsp_if_2.hst_par_oe <= 1'h0;
    @(negedge clk);
    chk("perr_two_late", 32'h0, u_phsp_if_2.perr_n);
    chk("perr_event", 32'h1, perr2);
    @(posedge clk);
    perr_clr <= 1'h1;
    @(negedge clk);
    chk("perr_seen", 32'h1, seen2);
    @(posedge clk);
    perr_clr <= 1'h0;
    @(negedge clk);
    chk("perr_cleared", 32'h0, seen2);
    // Demultiplexed mode: select line alone claims
    @(posedge clk);
    mode <= 1'h1;
    repeat (2) @(posedge clk);
    host_cfg(1'h1, 32'h0F0F_A5A5);
    chk("demultiplexed_bus_mode_done", 32'h1, h_done);
    repeat (3) @(negedge clk);
    chk("demultiplexed_bus_mode_we_count", 32'h2, n_we);
    chk("demultiplexed_bus_mode_wdata", 32'h0F0F_A5A5, we_d);
    chk("demultiplexed_bus_mode_par_low", 32'h0, par_hi);
    chk("main_no_perr", 32'h0, seen1);
    summarize();
  end
endmodule : pci_handshake_select_parity_test
`default_nettype wire

// *** tb/phsp_checker.sv ***
// Checker for claim, handshake and parity timing on the bus joining both ends
`timescale 1ns/1ps
`default_nettype none
module phsp_checker (
  // Clock, reset and mode
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  input wire logic I_DEMULTIPLEXED_BUS_MODE,
  // Resolved bus wires
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic perr_n,
  input wire logic idsel,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  // Device drive enables
  input wire logic dev_frame_oe,
  input wire logic dev_ad_oe,
  input wire logic dev_par_oe
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);
  // Claim and handshake hold relations
  a_cfg_claim_next: assert property ($fell(frame_n) && idsel && cbe[3:1] == 3'h5 |=> !devsel_n)
    else $error("config address not claimed next cycle");
  a_trdy_held: assert property (!trdy_n && irdy_n && stop_n |=> !trdy_n)
    else $error("target ready dropped before completion");
  a_irdy_held: assert property (!irdy_n && trdy_n && stop_n && !devsel_n |=> !irdy_n)
    else $error("initiator ready dropped before completion");
  a_devsel_held: assert property (!devsel_n && (irdy_n || trdy_n) && stop_n |=> !devsel_n)
    else $error("claim dropped inside data phase");
  a_trdy_claimed: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without claim");
  a_stop_ends_cycle: assert property ($fell(stop_n) |-> ##[1:3] (irdy_n && frame_n))
    else $error("initiator kept going after stop");
  a_abort_six: assert property ($fell(frame_n) && dev_frame_oe ##1 devsel_n [*6] |-> ##[0:2] irdy_n)
    else $error("unclaimed cycle not aborted");
  a_frame_single: assert property ($fell(frame_n) |=> frame_n)
    else $error("frame held past single data phase");
  // Parity generation and error timing
  a_par_even: assert property ($past(dev_ad_oe) && dev_par_oe && !I_DEMULTIPLEXED_BUS_MODE
    |-> par == ^{$past(ad), $past(cbe)})
    else $error("parity wrong or not one cycle late");
  a_par_demultiplexed_bus_mode_zero: assert property (I_DEMULTIPLEXED_BUS_MODE && $past(I_DEMULTIPLEXED_BUS_MODE, 2) |-> !par)
    else $error("parity driven in demultiplexed mode");
  a_perr_two_late: assert property ($fell(perr_n) |-> $past(par) != ^{$past(ad, 2), $past(cbe, 2)})
    else $error("parity error flagged without mismatch");
  // Main scenarios reached
  c_cfg_claim: cover property ($fell(frame_n) && idsel);
  c_data_done: cover property (!irdy_n && !trdy_n);
  c_target_stop: cover property ($fell(stop_n));
  c_demultiplexed_bus_mode_claim: cover property (I_DEMULTIPLEXED_BUS_MODE && !devsel_n);
endmodule : phsp_checker
`default_nettype wire
